// ### design/ibl_top.sv
// Service-program boot entry, region sizing and lock, with AXI4-Lite registers.
// Assumes reset causes arrive as levels and flash and CPU strobes are aclk-synchronous.
// Operation
// - Region sized in 256-byte blocks, zero to sixteen
// - Count zero: no service, whole flash usable
// - Sixteen blocks give 4K region, 60K left
// - Region starts at top minus count times 256
// - In-system erase spares the locked region
// - Protection makes all flash unreadable
// - Region locks automatically, writer-only erase
// - Entry loads PC with region start
// - Blank byte zero enters on hardware reset
// - Software jump to start enters service
// - Both port-two pins low enter service
// - Port-four pin low enters service
// - Two pulses on serial pin enter service
// - Pins sampled during reset, switch automatically
// - No entry while in power-down mode
// - Four reset-time mechanisms, each qualified by reset cause
// - Four read-only entry flags, cleared by reset
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
`include "ibl_params.svh"
module ibl_top
  import ibl_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        por_active,
  input  wire logic        pad_reset_active,
  input  wire logic        wdt_reset,
  input  wire logic        power_down,
  input  wire logic [7:0]  flash_byte_zero,
  input  wire logic        port2_pin6,
  input  wire logic        port2_pin7,
  input  wire logic        port4_pin3,
  input  wire logic        port3_pin0,
  input  wire logic        cpu_jump,
  input  wire logic [15:0] cpu_jump_addr,
  input  wire logic [15:0] flash_op_addr,
  input  wire logic        writer_code_done,
  input  wire logic        writer_erase,
  input  wire logic        chip_protect,
  output logic             pc_load,
  output logic [15:0]      pc_value,
  output logic             service_mode,
  output logic [15:0]      region_start,
  output logic             region_locked,
  output logic             flash_op_allow,
  output logic             flash_read_allow
);
  ibl_boot_st_t st_q;
  ibl_key_st_t  key_st_q;
  logic [4:0]   n_q;
  logic [7:0]   entry_en_q;
  logic [3:0]   flags_q;
  logic [7:0]   key_q;
  logic         upd_en_q;
  logic         locked_q;
  logic         protect_q;
  logic         svc_q;
  logic         pc_load_q;
  logic [15:0]  pc_q;
  logic         por_seen_q;
  logic         pad_seen_q;
  logic         p2_low_q;
  logic         p4_low_q;
  logic         blank_q;
  logic [7:0]   post_cnt_q;
  logic         pulses_two;
  logic [3:0]   cond;
  logic [3:0]   hits;
  logic         hw_rst;
  logic         in_region;
  logic         aw_q;
  logic         w_q;
  logic [11:0]  awaddr_q;
  logic [31:0]  wdata_q;
  logic [3:0]   wstrb_q;
  logic         bvalid_q;
  logic [1:0]   bresp_q;
  logic         rvalid_q;
  logic [1:0]   rresp_q;
  logic [31:0]  rdata_q;
  logic         wr_go;
  logic [11:0]  wa;
  logic [11:0]  ra;

  assign hw_rst = por_active || pad_reset_active;
  assign region_start = {`IBL_TOP_HI - {3'h0, n_q}, `IBL_LOW_ZERO};
  assign in_region = (n_q != `IBL_N_ZERO) && (flash_op_addr[15:8] >= region_start[15:8]);
  // The flash controller refuses program and erase on the spared region when this is low
  assign flash_op_allow = !(locked_q && in_region);
  assign flash_read_allow = !protect_q;
  assign region_locked = locked_q;
  assign pc_load = pc_load_q;
  assign pc_value = pc_q;
  assign service_mode = svc_q;

  // Boot decision sequencing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= IBL_ST_RUN;
      post_cnt_q <= 8'h00;
    end else begin
      case (st_q)
        IBL_ST_RUN: begin
          if (hw_rst) begin
            st_q <= IBL_ST_RST;
          end
        end
        IBL_ST_RST: begin
          if (!hw_rst) begin
            st_q <= IBL_ST_POST;
            post_cnt_q <= 8'h00;
          end
        end
        IBL_ST_POST: begin
          // Pulses may still arrive shortly after release
          if (hw_rst) begin
            st_q <= IBL_ST_RST;
          end else if (post_cnt_q == 8'(`IBL_POST_WIN_CYC - 1)) begin
            st_q <= IBL_ST_DEC;
          end else begin
            post_cnt_q <= post_cnt_q + 8'h01;
          end
        end
        IBL_ST_DEC: begin
          st_q <= hw_rst ? IBL_ST_RST : IBL_ST_RUN;
        end
        default: begin
          st_q <= IBL_ST_RUN;
        end
      endcase
    end
  end

  // Sampling of causes and pin levels over the reset period
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      por_seen_q <= 1'b0;
      pad_seen_q <= 1'b0;
      p2_low_q <= 1'b0;
      p4_low_q <= 1'b0;
      blank_q <= 1'b0;
    end else if (st_q == IBL_ST_RUN && hw_rst) begin
      por_seen_q <= por_active;
      pad_seen_q <= pad_reset_active;
      p2_low_q <= !port2_pin6 && !port2_pin7;
      p4_low_q <= !port4_pin3;
      blank_q <= (flash_byte_zero == `IBL_BLANK_BYTE);
    end else if (st_q == IBL_ST_RST) begin
      por_seen_q <= por_seen_q || por_active;
      pad_seen_q <= pad_seen_q || pad_reset_active;
      // A pin must stay low for the whole period to count
      p2_low_q <= p2_low_q && !port2_pin6 && !port2_pin7;
      p4_low_q <= p4_low_q && !port4_pin3;
      blank_q <= (flash_byte_zero == `IBL_BLANK_BYTE);
    end
  end

  ibl_pulse_counter u_pulses (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .clear    (st_q == IBL_ST_RUN && hw_rst),
    .enable   (st_q == IBL_ST_RST || st_q == IBL_ST_POST),
    .pin      (port3_pin0),
    .seen_two (pulses_two)
  );

  assign cond = {pulses_two, p4_low_q, p2_low_q, blank_q};
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      hits[i] = cond[i] && ((entry_en_q[2*i] && por_seen_q) || (entry_en_q[2*i+1] && pad_seen_q));
    end
  end

  // Program counter load and service mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      svc_q <= 1'b0;
      pc_load_q <= 1'b0;
      pc_q <= `IBL_PC_ZERO;
    end else begin
      pc_load_q <= 1'b0;
      if (st_q == IBL_ST_DEC) begin
        pc_load_q <= 1'b1;
        if ((n_q != `IBL_N_ZERO) && (|hits) && !power_down) begin
          svc_q <= 1'b1;
          pc_q <= region_start;
        end else begin
          svc_q <= 1'b0;
          pc_q <= `IBL_PC_ZERO;
        end
      end else if (st_q == IBL_ST_RUN && wdt_reset) begin
        svc_q <= 1'b0;
        pc_load_q <= 1'b1;
        pc_q <= `IBL_PC_ZERO;
      end else if (st_q == IBL_ST_RUN && cpu_jump) begin
        if (cpu_jump_addr == `IBL_PC_ZERO) begin
          svc_q <= 1'b0;
        end else if (cpu_jump_addr == region_start && n_q != `IBL_N_ZERO && !power_down) begin
          svc_q <= 1'b1;
        end
      end
    end
  end

  // Entry flags follow each boot decision
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_q <= 4'h0;
    end else if (st_q == IBL_ST_DEC) begin
      flags_q <= (n_q != `IBL_N_ZERO) ? hits : 4'h0;
    end
  end

  // Lock and protection; only the writer clears them
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      locked_q <= 1'b0;
      protect_q <= 1'b0;
    end else if (writer_erase) begin
      locked_q <= 1'b0;
      protect_q <= 1'b0;
    end else begin
      if (writer_code_done && n_q != `IBL_N_ZERO) begin
        locked_q <= 1'b1;
      end
      if (chip_protect) begin
        protect_q <= 1'b1;
      end
    end
  end

  // AXI4-Lite write path: address and data taken in either order
  assign s_axi_awready = !aw_q && !bvalid_q;
  assign s_axi_wready = !w_q && !bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign wr_go = aw_q && w_q && !bvalid_q;
  assign wa = {awaddr_q[11:2], 2'h0};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr_q <= 12'h000;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= `IBL_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= (wa == `IBL_OFF_CFG || wa == `IBL_OFF_CTRL || wa == `IBL_OFF_STAT ||
                    wa == `IBL_OFF_KEY) ? `IBL_RESP_OKAY : `IBL_RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Key register and its unlock sequence
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      key_q <= `IBL_KEY_RST;
      key_st_q <= IBL_KEY_IDLE;
    end else if (wr_go && wa == `IBL_OFF_KEY && wstrb_q[0]) begin
      key_q <= wdata_q[7:0];
      case (key_st_q)
        IBL_KEY_IDLE: key_st_q <= (wdata_q[7:0] == `IBL_KEY_1) ? IBL_KEY_ONE : IBL_KEY_IDLE;
        IBL_KEY_ONE:  key_st_q <= (wdata_q[7:0] == `IBL_KEY_2) ? IBL_KEY_TWO : IBL_KEY_IDLE;
        IBL_KEY_TWO:  key_st_q <= (wdata_q[7:0] == `IBL_KEY_3) ? IBL_KEY_OPEN : IBL_KEY_IDLE;
        default:      key_st_q <= (wdata_q[7:0] == `IBL_KEY_1) ? IBL_KEY_ONE : IBL_KEY_IDLE;
      endcase
    end else if (wr_go && wa == `IBL_OFF_CTRL) begin
      // One write attempt spends the unlock, whether or not it changes the bit
      key_st_q <= IBL_KEY_IDLE;
    end
  end

  // Update enable and configuration
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      upd_en_q <= 1'b0;
      n_q <= `IBL_N_ZERO;
      entry_en_q <= 8'h00;
    end else if (writer_erase) begin
      n_q <= `IBL_N_ZERO;
    end else if (wr_go && wa == `IBL_OFF_CTRL && wstrb_q[0] && key_st_q == IBL_KEY_OPEN) begin
      upd_en_q <= wdata_q[0];
    end else if (wr_go && wa == `IBL_OFF_CFG && upd_en_q) begin
      if (wstrb_q[0] && !locked_q && wdata_q[4:0] <= `IBL_N_MAX) begin
        n_q <= wdata_q[4:0];
      end
      if (wstrb_q[1]) begin
        entry_en_q <= wdata_q[15:8];
      end
    end
  end

  // AXI4-Lite read path
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;
  assign ra = {s_axi_araddr[11:2], 2'h0};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rresp_q <= `IBL_RESP_OKAY;
      rdata_q <= 32'h0000_0000;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_q <= 1'b1;
      rresp_q <= `IBL_RESP_OKAY;
      case (ra)
        `IBL_OFF_CFG:  rdata_q <= {16'h0000, entry_en_q, 3'h0, n_q};
        `IBL_OFF_CTRL: rdata_q <= {31'h0000_0000, upd_en_q};
        `IBL_OFF_STAT: rdata_q <= {region_start, 9'h000, protect_q, locked_q, svc_q, flags_q};
        `IBL_OFF_KEY:  rdata_q <= {24'h00_0000, key_q};
        default: begin
          rdata_q <= 32'h0000_0000;
          rresp_q <= `IBL_RESP_SLVERR;
        end
      endcase
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  sequence s_release;
    st_q == IBL_ST_RST ##1 st_q == IBL_ST_POST;
  endsequence
  sequence s_decide_enter;
    st_q == IBL_ST_DEC && n_q != `IBL_N_ZERO && (|hits) && !power_down;
  endsequence

  a_n0_boot_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_q == IBL_ST_DEC && n_q == `IBL_N_ZERO) |=> pc_load && pc_value == 16'h0000 && !service_mode)
    else $error("count zero did not boot address zero");
  a_max_region: assert property (@(posedge aclk) disable iff (!aresetn)
    n_q == `IBL_N_MAX |-> region_start == 16'hf000)
    else $error("sixteen blocks do not start at f000");
  a_entry_load: assert property (@(posedge aclk) disable iff (!aresetn)
    s_decide_enter |=> pc_load && service_mode && pc_value == region_start ##1 !pc_load)
    else $error("entry did not load region start for one cycle");
  a_locked_guard: assert property (@(posedge aclk) disable iff (!aresetn)
    (region_locked && n_q != 5'h00 && flash_op_addr[15:8] >= region_start[15:8]) |-> !flash_op_allow)
    else $error("locked region left open to erase");
  a_protect_read: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(chip_protect) && !$past(writer_erase) |-> !flash_read_allow)
    else $error("protected flash still readable");
  a_pd_no_entry: assert property (@(posedge aclk) disable iff (!aresetn)
    (power_down && !service_mode && !(st_q == IBL_ST_DEC && !power_down)) |=> !$rose(service_mode))
    else $error("entry taken in power-down");
  a_post_window: assert property (@(posedge aclk) disable iff (!aresetn)
    s_release ##1 !hw_rst [*8] |-> ##[1:100] st_q == IBL_ST_DEC || hw_rst)
    else $error("no decision after reset release");
  a_flag_source: assert property (@(posedge aclk) disable iff (!aresetn)
    $changed(flags_q) |-> $past(st_q) == IBL_ST_DEC)
    else $error("entry flags changed outside a decision");
  a_key_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    $changed(upd_en_q) |-> $past(key_st_q) == IBL_KEY_OPEN)
    else $error("update enable changed without key sequence");
  a_jump_entry: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_q == IBL_ST_RUN && !wdt_reset && cpu_jump && cpu_jump_addr == region_start &&
     n_q != 5'h00 && !power_down) |=> service_mode)
    else $error("jump to region start did not enter service");
endmodule

// ### inc/ibl_params.svh
// Constants of the service-program entry and lock block.
// Assumes a 10 MHz aclk and a 12-bit AXI4-Lite byte address.
`ifndef IBL_PARAMS_SVH
`define IBL_PARAMS_SVH
`define IBL_OFF_CFG      12'h000
`define IBL_OFF_CTRL     12'h004
`define IBL_OFF_STAT     12'h008
`define IBL_KEY_INDEX    12'h0f7
`define IBL_OFF_KEY      12'h3dc
`define IBL_N_MAX        5'h10
`define IBL_N_ZERO       5'h00
`define IBL_BLANK_BYTE   8'hff
`define IBL_KEY_1        8'h55
`define IBL_KEY_2        8'haa
`define IBL_KEY_3        8'h5a
`define IBL_KEY_RST      8'h00
`define IBL_PC_ZERO      16'h0000
`define IBL_TOP_HI       8'h00
`define IBL_LOW_ZERO     8'h00
`define IBL_RESP_OKAY    2'h0
`define IBL_RESP_SLVERR  2'h2
`define IBL_CLK_NS       100
`define IBL_POST_WIN_NS  10000
`define IBL_POST_WIN_CYC (((`IBL_POST_WIN_NS) + (`IBL_CLK_NS) - 1) / (`IBL_CLK_NS))
`define IBL_PULSES_REQ   2'h2
`endif

// ### inc/ibl_pkg.sv
// Types of the service-program entry and lock block.
// Assumes ibl_params.svh supplies the numeric constants.
package ibl_pkg;
  typedef enum logic [1:0] {
    IBL_ST_RUN  = 2'b00,
    IBL_ST_RST  = 2'b01,
    IBL_ST_POST = 2'b10,
    IBL_ST_DEC  = 2'b11
  } ibl_boot_st_t;
  typedef enum logic [1:0] {
    IBL_KEY_IDLE = 2'b00,
    IBL_KEY_ONE  = 2'b01,
    IBL_KEY_TWO  = 2'b10,
    IBL_KEY_OPEN = 2'b11
  } ibl_key_st_t;
endpackage

// ### design/ibl_pulse_counter.sv
// Counts rising edges of a serial pin while enabled, saturating at two.
// Assumes the pin is synchronous to aclk.
`timescale 1ns/1ps
`include "ibl_params.svh"
module ibl_pulse_counter
  import ibl_pkg::*;
(
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic clear,
  input  wire logic enable,
  input  wire logic pin,
  output logic      seen_two
);
  logic       pin_q;
  logic [1:0] cnt_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= pin;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || clear) begin
      cnt_q <= 2'h0;
    end else if (enable && pin && !pin_q && cnt_q != `IBL_PULSES_REQ) begin
      cnt_q <= cnt_q + 2'h1;
    end
  end

  assign seen_two = (cnt_q == `IBL_PULSES_REQ);
endmodule

// ### verification/ibl_strap_model.sv
// Far-side model: flash byte at address zero and the reset-time strap pins.
// Assumes the bench steers it from the aclk domain.
`timescale 1ns/1ps
`include "ibl_params.svh"
module ibl_strap_model (
  input  wire logic       aclk,
  input  wire logic       blank,
  input  wire logic       p2_low,
  input  wire logic       p4_low,
  input  wire logic       pulse_go,
  output logic [7:0]      flash_byte_zero,
  output logic            port2_pin6,
  output logic            port2_pin7,
  output logic            port4_pin3,
  output logic            port3_pin0
);
  // Two high phases give exactly two rising edges; the pin idles low between bursts
  logic [3:0] burst_q = 4'h0;
  assign flash_byte_zero = blank ? `IBL_BLANK_BYTE : 8'h02;
  // Straps sit high unless entry is wanted, as a real system must keep them
  assign port2_pin6 = !p2_low;
  assign port2_pin7 = !p2_low;
  assign port4_pin3 = !p4_low;
  assign port3_pin0 = burst_q[0];
  always_ff @(posedge aclk) begin
    if (pulse_go) begin
      burst_q <= 4'h5;
    end else begin
      burst_q <= {1'h0, burst_q[3:1]};
    end
  end
endmodule

// ### verification/tb_top.sv
// Self-checking bench for the service-entry and lock block.
// Assumes ibl_top and its AXI4-Lite map, with the strap model on the pins.
`timescale 1ns/1ps
`include "ibl_params.svh"
module tb_top;
  logic        aclk = 1'h0, aresetn = 1'h0;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic        por_active = 1'h0, pad_reset_active = 1'h0, wdt_reset = 1'h0, power_down = 1'h0;
  logic        cpu_jump = 1'h0, writer_code_done = 1'h0, writer_erase = 1'h0, chip_protect = 1'h0;
  logic [15:0] cpu_jump_addr = 16'h0, flash_op_addr = 16'h0;
  logic        blank = 1'h0, p2 = 1'h0, p4 = 1'h0, pgo = 1'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        pc_load, service_mode, region_locked, flash_op_allow, flash_read_allow;
  logic        port2_pin6, port2_pin7, port4_pin3, port3_pin0;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [31:0] s_axi_rdata, d;
  logic [15:0] pc_value, region_start, xs = 16'h0;
  logic [7:0]  flash_byte_zero;
  int          err_total = 0;
  int          check_count = 0;

  ibl_top DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .por_active, .pad_reset_active, .wdt_reset, .power_down, .flash_byte_zero,
    .port2_pin6, .port2_pin7, .port4_pin3, .port3_pin0, .cpu_jump, .cpu_jump_addr, .flash_op_addr,
    .writer_code_done, .writer_erase, .chip_protect, .pc_load, .pc_value, .service_mode,
    .region_start, .region_locked, .flash_op_allow, .flash_read_allow);
  ibl_strap_model strap_m (.aclk, .blank, .p2_low(p2), .p4_low(p4), .pulse_go(pgo), .flash_byte_zero,
    .port2_pin6, .port2_pin7, .port4_pin3, .port3_pin0);

  initial begin
    forever #50 aclk = ~aclk;
  end

  task automatic results();
    begin
      $display("Checks %0d, mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
        $display("Run complete: PASS");
      end else begin
        $display("Run complete: FAIL");
      end
      $finish;
    end
  endtask

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    begin
      check_count++;
      if (s !== e) begin
        $display("[FAIL] %s expected %h seen %h", nm, e, s);
        err_total++;
      end
    end
  endtask

  task automatic tout(input int n);
    begin
      if (n > 300) begin
        $display("[FAIL] wait expected answer seen none");
        err_total++;
        results();
      end
    end
  endtask

  // Handshakes are judged at the falling edge so the rising edge never races the slave
  task automatic axw(input logic [11:0] a, input logic [31:0] v, output logic [1:0] rs);
    int n;
    logic aw, w, b;
    logic [2:0] tk;
    begin
      n = 0;
      aw = 1'h1;
      w = 1'h1;
      b = 1'h1;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      while (b) begin
        @(negedge aclk);
        tk = {aw && s_axi_awready, w && s_axi_wready, s_axi_bvalid};
        rs = s_axi_bresp;
        @(posedge aclk);
        if (tk[2]) begin
          aw = 1'h0;
          s_axi_awvalid <= 1'h0;
        end
        if (tk[1]) begin
          w = 1'h0;
          s_axi_wvalid <= 1'h0;
        end
        if (tk[0]) begin
          b = 1'h0;
          s_axi_bready <= 1'h0;
        end
        n++;
        tout(n);
      end
    end
  endtask

  task automatic axr(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
    int n;
    logic ar, rd;
    logic [1:0] tk;
    begin
      n = 0;
      ar = 1'h1;
      rd = 1'h1;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      while (rd) begin
        @(negedge aclk);
        tk = {ar && s_axi_arready, s_axi_rvalid};
        v = s_axi_rdata;
        rs = s_axi_rresp;
        @(posedge aclk);
        if (tk[1]) begin
          ar = 1'h0;
          s_axi_arvalid <= 1'h0;
        end
        if (tk[0]) begin
          rd = 1'h0;
          s_axi_rready <= 1'h0;
        end
        n++;
        tout(n);
      end
    end
  endtask

  task automatic pulse_wait();
    int n;
    begin
      n = 0;
      do begin
        @(negedge aclk);
        n++;
      end while (pc_load !== 1'h1 && n <= 300);
      tout(n);
    end
  endtask

  task automatic strap(input logic b, input logic l2, input logic l4, input logic pd);
    begin
      @(posedge aclk);
      blank <= b;
      p2 <= l2;
      p4 <= l4;
      power_down <= pd;
    end
  endtask

  // Straps stay put through the whole reset and decision, as the entry pins demand
  task automatic boot(input logic cause, input logic pls, input logic esm, input logic [3:0] efl,
                      input logic fc);
    begin
      @(posedge aclk);
      por_active <= !cause;
      pad_reset_active <= cause;
      @(posedge aclk);
      pgo <= pls;
      @(posedge aclk);
      pgo <= 1'h0;
      repeat (5) @(posedge aclk);
      por_active <= 1'h0;
      pad_reset_active <= 1'h0;
      pulse_wait();
      chk("boot pc", 32'(pc_value), 32'(esm ? xs : 16'h0));
      chk("boot mode", 32'(service_mode), 32'(esm));
      axr(`IBL_OFF_STAT, d, r);
      if (fc) begin
        chk("entry flags", 32'(d[3:0]), 32'(efl));
      end
    end
  endtask

  task automatic jump(input logic [15:0] a, input logic pd, input logic esm);
    begin
      @(posedge aclk);
      cpu_jump <= 1'h1;
      cpu_jump_addr <= a;
      power_down <= pd;
      @(posedge aclk);
      cpu_jump <= 1'h0;
      @(negedge aclk);
      chk("jump mode", 32'(service_mode), 32'(esm));
    end
  endtask

  // One-cycle strobes: bit 3 watchdog, 2 code done, 1 chip protect, 0 writer erase
  task automatic tick(input logic [3:0] m);
    begin
      @(posedge aclk);
      {wdt_reset, writer_code_done, chip_protect, writer_erase} <= m;
      @(posedge aclk);
      {wdt_reset, writer_code_done, chip_protect, writer_erase} <= 4'h0;
      @(negedge aclk);
    end
  endtask

  task automatic t_regs();
    begin
      axr(`IBL_OFF_STAT, d, r);
      chk("stat reset", d, 32'h0);
      axr(`IBL_OFF_KEY, d, r);
      chk("key reset", d, 32'h0);
      axr(12'hff0, d, r);
      chk("unmapped rresp", 32'(r), 32'(`IBL_RESP_SLVERR));
      axw(12'hff0, 32'h1, r);
      chk("unmapped bresp", 32'(r), 32'(`IBL_RESP_SLVERR));
      axw(`IBL_OFF_CTRL, 32'h1, r);
      axw(`IBL_OFF_CFG, 32'hff04, r);
      chk("cfg without key", 32'(region_start), 32'h0);
      $display("Register test done");
    end
  endtask

  task automatic t_size();
    logic [4:0] n;
    begin
      axw(`IBL_OFF_KEY, 32'h55, r);
      axw(`IBL_OFF_KEY, 32'haa, r);
      axw(`IBL_OFF_KEY, 32'h5a, r);
      axw(`IBL_OFF_CTRL, 32'h1, r);
      for (int i = 0; i < 3; i++) begin
        n = (i == 0) ? 5'h01 : (i == 1) ? 5'h0b : `IBL_N_MAX;
        axw(`IBL_OFF_CFG, {16'h0, 8'hff, 3'h0, n}, r);
        xs = 16'h0 - {3'h0, n, 8'h00};
        chk("region start", 32'(region_start), 32'(xs));
        axr(`IBL_OFF_STAT, d, r);
        chk("stat start", 32'(d[31:16]), 32'(xs));
      end
      axw(`IBL_OFF_CFG, 32'hff11, r);
      chk("count above max", 32'(region_start), 32'hf000);
      $display("Sizing test done");
    end
  endtask

  task automatic t_boot();
    begin
      strap(1'h1, 1'h0, 1'h0, 1'h0);
      boot(1'h0, 1'h0, 1'h1, 4'h1, 1'h1);
      boot(1'h1, 1'h0, 1'h1, 4'h1, 1'h1);
      strap(1'h0, 1'h1, 1'h0, 1'h0);
      boot(1'h1, 1'h0, 1'h1, 4'h2, 1'h1);
      strap(1'h0, 1'h0, 1'h1, 1'h0);
      boot(1'h0, 1'h0, 1'h1, 4'h4, 1'h1);
      strap(1'h0, 1'h0, 1'h0, 1'h0);
      boot(1'h1, 1'h1, 1'h1, 4'h8, 1'h1);
      boot(1'h0, 1'h0, 1'h0, 4'h0, 1'h1);
      strap(1'h1, 1'h0, 1'h0, 1'h1);
      boot(1'h0, 1'h0, 1'h0, 4'h1, 1'h1);
      strap(1'h1, 1'h0, 1'h0, 1'h0);
      axw(`IBL_OFF_CFG, 32'hfe10, r);
      boot(1'h0, 1'h0, 1'h0, 4'h0, 1'h0);
      boot(1'h1, 1'h0, 1'h1, 4'h1, 1'h1);
      axw(`IBL_OFF_CFG, 32'hff10, r);
      $display("Boot test done");
    end
  endtask

  task automatic t_jump();
    begin
      jump(16'h0, 1'h0, 1'h0);
      jump(xs, 1'h1, 1'h0);
      jump(xs, 1'h0, 1'h1);
      tick(4'h8);
      chk("wdt load", 32'(pc_load), 32'h1);
      chk("wdt pc", 32'(pc_value), 32'h0);
      chk("wdt mode", 32'(service_mode), 32'h0);
      $display("Jump test done");
    end
  endtask

  task automatic t_lock();
    begin
      @(posedge aclk);
      flash_op_addr <= xs;
      tick(4'h4);
      chk("locked", 32'(region_locked), 32'h1);
      chk("erase in region", 32'(flash_op_allow), 32'h0);
      chk("read open", 32'(flash_read_allow), 32'h1);
      @(posedge aclk);
      flash_op_addr <= xs - 16'h1;
      tick(4'h2);
      chk("erase below region", 32'(flash_op_allow), 32'h1);
      chk("read closed", 32'(flash_read_allow), 32'h0);
      axw(`IBL_OFF_CFG, 32'hff04, r);
      chk("count held", 32'(region_start), 32'(xs));
      axr(`IBL_OFF_STAT, d, r);
      chk("stat lock bits", 32'(d[6:5]), 32'h3);
      tick(4'h1);
      chk("writer erase", 32'({region_locked, flash_read_allow, region_start}), 32'h10000);
      $display("Lock test done");
    end
  endtask

  task automatic t_zero();
    begin
      strap(1'h1, 1'h1, 1'h1, 1'h0);
      boot(1'h0, 1'h1, 1'h0, 4'h0, 1'h1);
      @(posedge aclk);
      flash_op_addr <= 16'hffff;
      @(negedge aclk);
      chk("whole flash usable", 32'(flash_op_allow), 32'h1);
      $display("Zero count test done");
    end
  endtask

  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    t_regs();
    t_size();
    t_boot();
    t_jump();
    t_lock();
    t_zero();
    results();
  end
endmodule
